// *** hdl/crcu_byte_step.sv ***
`default_nettype none

module crcu_byte_step (
    input  wire logic [31:0] crc_in,
    input  wire logic [7:0]  data_in,
    input  wire logic [31:0] select_a,
    input  wire logic        wide,
    output logic      [31:0] crc_out
);

    logic [31:0] c;
    logic        msb;

    // Bitwise long division, eight shifts per byte, MSB first
    always_comb begin
        c   = wide ? (crc_in ^ {data_in, 24'h000000})
                   : {16'h0000, crc_in[15:0] ^ {data_in, 8'h00}};
        msb = 1'b0;
        for (int i = 0; i < 8; i++) begin
            msb = wide ? c[31] : c[15];
            c   = {c[30:0], 1'b0} ^ (msb ? select_a : 32'h0000_0000);
        end
        crc_out = wide ? c : {16'h0000, c[15:0]};
    end

endmodule

`default_nettype wire

// *** hdl/crcu_pkg.sv ***
// Overview of operation
// (RULE_01) Select field: 00 picks 0x1021, 01 picks 0x8005, 1x picks 0x04C11DB7.
// (RULE_02) Only the three fixed generator polynomials exist; none is programmable.
// (RULE_03) Each input data write folds its data into the running checksum; a write with pstrb of zero is ignored and folds nothing.
// (RULE_04) Data is processed a byte per step, most significant byte and bit first.
// (RULE_05) Input data accepts word, right-aligned half-word and right-aligned byte writes.
// (RULE_06) Software uses only full-word transfers on control, seed and checksum.
// (RULE_07) An update takes 4 cycles per word, 2 per half-word, 1 per byte.
// (RULE_08) Swap and flip options apply to input data or checksum output separately.
// (RULE_09) Input byte swap acts only on word and half-word writes.
// (RULE_10) Byte writes ignore input byte swap but still get input bit flip.
// (RULE_11) Control bit 4 inverts every input data bit before calculation.
// (RULE_12) Control bit 3 reverses input byte order before calculation.
// (RULE_13) Control bit 2 reverses bit order within each input byte.
// (RULE_14) Control bit 7 inverts the checksum as read.
// (RULE_15) Control bit 6 reverses the checksum byte order as read.
// (RULE_16) Control bit 5 reverses bit order within each checksum byte as read.
// (RULE_17) Software writes a seed whose width matches the selected polynomial.
// (RULE_18) The read-only checksum register shows the latest calculation result.
// (RULE_19) Remainder is 16 bits for the 16-bit polynomials, 32 bits otherwise.
// (RULE_20) The input data register is write-only and only feeds the engine.
// (RULE_21) A seed write loads the running state for the next data write.
// (RULE_22) With a 16-bit polynomial state sits in the low half; upper reads zero.
`default_nettype none

package crcu_pkg;

    // ========================================
    // Register map
    localparam int          ADDR_W          = 12;
    localparam logic [11:0] OFS_CONTROL     = 12'h000;
    localparam logic [11:0] OFS_SEED        = 12'h004;
    localparam logic [11:0] OFS_CHECKSUM    = 12'h008;
    localparam logic [11:0] OFS_INPUT_DATA  = 12'h00c;
    localparam logic [7:0]  CONTROL_RESET   = 8'h00;
    localparam logic [31:0] CRC_RESET       = 32'h0000_0000;

    // ========================================
    // Control field positions
    localparam int BIT_OUT_INVERT   = 7;
    localparam int BIT_OUT_BYTE_SW  = 6;
    localparam int BIT_OUT_BIT_FLIP = 5;
    localparam int BIT_IN_INVERT    = 4;
    localparam int BIT_IN_BYTE_SW   = 3;
    localparam int BIT_IN_BIT_FLIP  = 2;
    localparam int BIT_SEL_HI       = 1;
    localparam int BIT_SEL_LO       = 0;

    // ========================================
    // Fixed generator polynomials
    localparam logic [31:0] SELECT_A_CCITT = 32'h0000_1021;
    localparam logic [31:0] SELECT_A_CRC16 = 32'h0000_8005;
    localparam logic [31:0] SELECT_A_CRC32 = 32'h04c1_1db7;

    // ========================================
    // Cycles per update, one byte per cycle
    localparam logic [2:0] CYC_WORD = 3'h4;
    localparam logic [2:0] CYC_HALF = 3'h2;
    localparam logic [2:0] CYC_BYTE = 3'h1;

    typedef enum logic [1:0] {
        CRCU_IDLE   = 2'b00,
        CRCU_RUN    = 2'b01,
        CRCU_SETTLE = 2'b10
    } crcu_state_t;

endpackage

`default_nettype wire

// *** hdl/crcu_top.sv ***
// The APB register port was decided locally.
`default_nettype none

module crcu_top (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr
);

    // ========================================
    // State
    logic [7:0]                crc_control_ff;
    logic [31:0]               crc_ff;
    logic [31:0]               shift_ff;
    logic [2:0]                count_ff;
    logic [31:0]               prdata_ff;
    crcu_pkg::crcu_state_t     state_ff;
    crcu_pkg::crcu_state_t     nxt_state;

    logic        access;
    logic        hit_control;
    logic        hit_seed;
    logic        hit_checksum;
    logic        hit_input;
    logic        unmapped;
    logic        wr_control;
    logic        wr_seed;
    logic        wr_input;
    logic        is_word;
    logic        is_half;
    logic        is_byte;
    logic        select_a_wide;
    logic [31:0] select_a_sel;
    logic [31:0] step_out;
    logic [31:0] in_data;
    logic [31:0] in_aligned;
    logic [2:0]  in_count;
    logic [31:0] checksum_value;
    logic [31:0] read_mux;

    // ========================================
    // Helpers
    function automatic logic [31:0] flip_bytes(input logic [31:0] v);
        logic [31:0] r;
        r = 32'h0000_0000;
        for (int b = 0; b < 4; b++) begin
            for (int k = 0; k < 8; k++) begin
                r[b*8 + k] = v[b*8 + 7 - k];
            end
        end
        return r;
    endfunction

    // ========================================
    // APB decode
    assign hit_control  = (paddr == crcu_pkg::OFS_CONTROL);
    assign hit_seed     = (paddr == crcu_pkg::OFS_SEED);
    assign hit_checksum = (paddr == crcu_pkg::OFS_CHECKSUM);
    assign hit_input    = (paddr == crcu_pkg::OFS_INPUT_DATA);
    assign unmapped     = !(hit_control || hit_seed || hit_checksum || hit_input);

    // Wait states while an update runs, so reads never see a half result
    assign pready  = penable && (state_ff == crcu_pkg::CRCU_IDLE); // RULE_07
    assign pslverr = psel && penable && pready && unmapped;
    assign prdata  = prdata_ff;
    assign access  = psel && penable && pready && !unmapped;

    assign wr_control = access && pwrite && hit_control;
    assign wr_seed    = access && pwrite && hit_seed;
    assign wr_input   = access && pwrite && hit_input && (pstrb != 4'h0);

    // Size from the strobes of a right-aligned write
    assign is_word = (pstrb[3:2] != 2'b00); // RULE_05
    assign is_half = !is_word && pstrb[1];
    assign is_byte = !is_word && !pstrb[1];

    // ========================================
    // Polynomial choice, no programmable value
    assign select_a_wide = crc_control_ff[crcu_pkg::BIT_SEL_HI]; // RULE_19
    always_comb begin
        if (crc_control_ff[crcu_pkg::BIT_SEL_HI]) begin // RULE_01
            select_a_sel = crcu_pkg::SELECT_A_CRC32; // RULE_02
        end else if (crc_control_ff[crcu_pkg::BIT_SEL_LO]) begin
            select_a_sel = crcu_pkg::SELECT_A_CRC16;
        end else begin
            select_a_sel = crcu_pkg::SELECT_A_CCITT;
        end
    end

    // ========================================
    // Input shaping
    always_comb begin
        in_data = pwdata;
        if (crc_control_ff[crcu_pkg::BIT_IN_INVERT]) begin
            in_data = ~in_data; // RULE_11
        end
        // Byte writes bypass the swap; one byte has no order
        if (crc_control_ff[crcu_pkg::BIT_IN_BYTE_SW] && !is_byte) begin // RULE_09 RULE_10
            if (is_word) begin // RULE_12
                in_data = {in_data[7:0], in_data[15:8], in_data[23:16], in_data[31:24]};
            end else begin
                in_data = {16'h0000, in_data[7:0], in_data[15:8]};
            end
        end
        if (crc_control_ff[crcu_pkg::BIT_IN_BIT_FLIP]) begin // RULE_13 RULE_10
            in_data = flip_bytes(in_data);
        end
        // First byte to process goes to the top, big-endian
        if (is_word) begin // RULE_04
            in_aligned = in_data;
            in_count   = crcu_pkg::CYC_WORD;
        end else if (is_half) begin
            in_aligned = {in_data[15:0], 16'h0000};
            in_count   = crcu_pkg::CYC_HALF;
        end else begin
            in_aligned = {in_data[7:0], 24'h000000};
            in_count   = crcu_pkg::CYC_BYTE;
        end
    end

    // ========================================
    // Engine
    crcu_byte_step u_step (
        .crc_in  (crc_ff),
        .data_in (shift_ff[31:24]),
        .select_a    (select_a_sel),
        .wide    (select_a_wide),
        .crc_out (step_out)
    );

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            crcu_pkg::CRCU_IDLE: begin
                if (wr_input) begin
                    nxt_state = crcu_pkg::CRCU_RUN;
                end
            end
            crcu_pkg::CRCU_RUN: begin
                if (count_ff == 3'h1) begin // RULE_07
                    nxt_state = crcu_pkg::CRCU_SETTLE;
                end
            end
            // One spare cycle lets the read register catch the final value
            crcu_pkg::CRCU_SETTLE: nxt_state = crcu_pkg::CRCU_IDLE;
            default:               nxt_state = crcu_pkg::CRCU_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= crcu_pkg::CRCU_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shift_ff <= 32'h0000_0000;
            count_ff <= 3'h0;
        end else if (wr_input) begin
            shift_ff <= in_aligned;
            count_ff <= in_count;
        end else if (state_ff == crcu_pkg::CRCU_RUN) begin
            shift_ff <= {shift_ff[23:0], 8'h00};
            count_ff <= count_ff - 3'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            crc_ff <= crcu_pkg::CRC_RESET;
        end else if (wr_seed) begin
            crc_ff <= select_a_wide ? pwdata : {16'h0000, pwdata[15:0]}; // RULE_21 RULE_22
        end else if (state_ff == crcu_pkg::CRCU_RUN) begin
            crc_ff <= step_out; // RULE_03
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            crc_control_ff <= crcu_pkg::CONTROL_RESET;
        end else if (wr_control) begin
            crc_control_ff <= pwdata[7:0];
        end
    end

    // ========================================
    // Checksum output shaping
    always_comb begin
        checksum_value = select_a_wide ? crc_ff : {16'h0000, crc_ff[15:0]}; // RULE_22
        if (crc_control_ff[crcu_pkg::BIT_OUT_BIT_FLIP]) begin // RULE_16 RULE_08
            checksum_value = flip_bytes(checksum_value);
        end
        if (crc_control_ff[crcu_pkg::BIT_OUT_BYTE_SW]) begin // RULE_15
            checksum_value = select_a_wide
                ? {checksum_value[7:0], checksum_value[15:8],
                   checksum_value[23:16], checksum_value[31:24]}
                : {16'h0000, checksum_value[7:0], checksum_value[15:8]};
        end
        if (crc_control_ff[crcu_pkg::BIT_OUT_INVERT]) begin // RULE_14
            checksum_value = select_a_wide ? ~checksum_value
                                       : {16'h0000, ~checksum_value[15:0]};
        end
    end

    // Write-only registers read as zero
    always_comb begin
        read_mux = 32'h0000_0000; // RULE_20
        if (hit_control) begin
            read_mux = {24'h000000, crc_control_ff};
        end else if (hit_checksum) begin
            read_mux = checksum_value; // RULE_18
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= 32'h0000_0000;
        end else if (psel && !pwrite) begin
            prdata_ff <= read_mux;
        end
    end

    // ========================================
    // Checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_word_cycles: assert property ( // RULE_07
        (wr_input && is_word) |=> (state_ff == crcu_pkg::CRCU_RUN) [*4]
            ##1 (state_ff == crcu_pkg::CRCU_SETTLE))
        else $error("word update not four cycles");

    a_half_cycles: assert property ( // RULE_07
        (wr_input && is_half) |=> (state_ff == crcu_pkg::CRCU_RUN) [*2]
            ##1 (state_ff == crcu_pkg::CRCU_SETTLE))
        else $error("half-word update not two cycles");

    a_byte_cycles: assert property ( // RULE_07
        (wr_input && is_byte) |=> (state_ff == crcu_pkg::CRCU_RUN)
            ##1 (state_ff == crcu_pkg::CRCU_SETTLE))
        else $error("byte update not one cycle");

    a_busy_wait: assert property ( // RULE_07
        (state_ff != crcu_pkg::CRCU_IDLE) |-> !pready)
        else $error("ready while engine busy");

    a_fold_step: assert property ( // RULE_03
        (state_ff == crcu_pkg::CRCU_RUN) |=> (crc_ff == $past(step_out)))
        else $error("state not folded by byte step");

    a_seed_load: assert property ( // RULE_21
        (wr_seed && select_a_wide) |=> (crc_ff == $past(pwdata)))
        else $error("seed not loaded");

    a_seed_narrow: assert property ( // RULE_22
        (wr_seed && !select_a_wide) |=> (crc_ff[31:16] == 16'h0000)
            && (crc_ff[15:0] == $past(pwdata[15:0])))
        else $error("narrow seed upper half not zero");

    a_read_checksum: assert property ( // RULE_18
        (access && !pwrite && hit_checksum) |-> (prdata == checksum_value))
        else $error("checksum read mismatch");

    a_input_reads_zero: assert property ( // RULE_20
        (access && !pwrite && (hit_input || hit_seed)) |-> (prdata == 32'h0000_0000))
        else $error("write-only register read nonzero");

    a_select_a_pick: assert property ( // RULE_01
        (state_ff == crcu_pkg::CRCU_RUN) |-> (select_a_sel == (crc_control_ff[1]
            ? crcu_pkg::SELECT_A_CRC32 : (crc_control_ff[0]
            ? crcu_pkg::SELECT_A_CRC16 : crcu_pkg::SELECT_A_CCITT))))
        else $error("wrong polynomial selected");

    a_run_count: assert property ( // RULE_07
        (state_ff == crcu_pkg::CRCU_RUN)
            |-> (count_ff != 3'h0) && (count_ff <= crcu_pkg::CYC_WORD))
        else $error("byte counter out of range while running");

    a_state_hold: assert property ( // RULE_03
        (state_ff != crcu_pkg::CRCU_RUN && !wr_seed) |=> $stable(crc_ff))
        else $error("running state changed without a fold or seed");

    a_checksum_ro: assert property ( // RULE_18
        (access && pwrite && hit_checksum) |=> $stable(crc_ff) && $stable(crc_control_ff))
        else $error("write to checksum register changed state");

    a_narrow_fold: assert property ( // RULE_22
        (state_ff == crcu_pkg::CRCU_RUN && !select_a_wide) |=> (crc_ff[31:16] == 16'h0000))
        else $error("narrow fold left upper state bits set");

    a_narrow_read: assert property ( // RULE_19
        !select_a_wide |-> (checksum_value[31:16] == 16'h0000))
        else $error("narrow checksum upper half not zero");

    a_ctrl_read: assert property ( // RULE_08
        (access && !pwrite && hit_control) |-> (prdata == {24'h000000, crc_control_ff}))
        else $error("control read-back mismatch");

    a_byte_plain: assert property ( // RULE_10
        (wr_input && is_byte && !crc_control_ff[crcu_pkg::BIT_IN_INVERT]
            && !crc_control_ff[crcu_pkg::BIT_IN_BIT_FLIP])
            |=> (shift_ff[31:24] == $past(pwdata[7:0])))
        else $error("byte write reordered");

    a_byte_invert: assert property ( // RULE_11
        (wr_input && is_byte && crc_control_ff[crcu_pkg::BIT_IN_INVERT]
            && !crc_control_ff[crcu_pkg::BIT_IN_BIT_FLIP])
            |=> (shift_ff[31:24] == ~$past(pwdata[7:0])))
        else $error("byte write not inverted");

    a_word_swap: assert property ( // RULE_12
        (wr_input && is_word && crc_control_ff[crcu_pkg::BIT_IN_BYTE_SW]
            && !crc_control_ff[crcu_pkg::BIT_IN_INVERT]
            && !crc_control_ff[crcu_pkg::BIT_IN_BIT_FLIP])
            |=> (shift_ff == {$past(pwdata[7:0]), $past(pwdata[15:8]),
                              $past(pwdata[23:16]), $past(pwdata[31:24])}))
        else $error("word write not byte swapped");

    a_half_align: assert property ( // RULE_05
        (wr_input && is_half && !crc_control_ff[crcu_pkg::BIT_IN_BYTE_SW]
            && !crc_control_ff[crcu_pkg::BIT_IN_INVERT]
            && !crc_control_ff[crcu_pkg::BIT_IN_BIT_FLIP])
            |=> (shift_ff == {$past(pwdata[15:0]), 16'h0000}))
        else $error("half-word not aligned to top");

    a_out_invert: assert property ( // RULE_14
        (crc_control_ff[crcu_pkg::BIT_OUT_INVERT] && !crc_control_ff[crcu_pkg::BIT_OUT_BYTE_SW]
            && !crc_control_ff[crcu_pkg::BIT_OUT_BIT_FLIP] && !select_a_wide)
            |-> (checksum_value == {16'h0000, ~crc_ff[15:0]}))
        else $error("checksum not inverted");

    c_word_write: cover property (wr_input && is_word ##6 state_ff == crcu_pkg::CRCU_IDLE);
    c_half_write: cover property (wr_input && is_half);
    c_byte_write: cover property (wr_input && is_byte);
    c_read_wide:  cover property (access && !pwrite && hit_checksum && select_a_wide);
    c_busy_stall: cover property (psel && penable && !pready);

endmodule

`default_nettype wire

// *** verif/tb_crc_calculation_unit.sv ***
`default_nettype none

module tb_crc_calculation_unit;
    timeunit 1ns;
    timeprecision 1ps;

    // ========================================
    // Signals
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    int          num_errors;
    int          comparisons;
    logic [31:0] m_state;

    crcu_top i_dut (
        .pclk    (pclk),
        .presetn (presetn),
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .paddr   (paddr),
        .pwdata  (pwdata),
        .pstrb   (pstrb),
        .prdata  (prdata),
        .pready  (pready),
        .pslverr (pslverr)
    );

    always #12.5 pclk = ~pclk;

    // ========================================
    // Reference model, kept apart from the engine
    function automatic logic [31:0] flip4(logic [31:0] x);
        logic [31:0] y;
        for (int i = 0; i < 32; i++) y[i] = x[(i / 8) * 8 + 7 - (i % 8)];
        return y;
    endfunction

    function automatic logic [31:0] step(logic [31:0] s, logic [7:0] d, logic [1:0] sel);
        logic [31:0] p;
        p = sel[1] ? 32'h04c1_1db7 : (sel[0] ? 32'h0000_8005 : 32'h0000_1021);
        if (sel[1]) s = s ^ {d, 24'h0};
        else s[15:8] = s[15:8] ^ d;
        for (int i = 0; i < 8; i++) begin
            if (sel[1]) s = s[31] ? ((s << 1) ^ p) : (s << 1);
            else s[15:0] = s[15] ? ((s[15:0] << 1) ^ p[15:0]) : (s[15:0] << 1);
        end
        return s;
    endfunction

    function automatic logic [31:0] shown(logic [31:0] m, logic [7:0] c);
        logic [31:0] v;
        v = c[1] ? m : {16'h0, m[15:0]};
        if (c[5]) v = flip4(v);
        if (c[6]) v = c[1] ? {v[7:0], v[15:8], v[23:16], v[31:24]} : {16'h0, v[7:0], v[15:8]};
        if (c[7]) v = c[1] ? ~v : {16'h0, ~v[15:0]};
        return v;
    endfunction

    // ========================================
    // Bus and checking
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] s, output logic [31:0] rd, output logic err,
                       output int n);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= s;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 64);
        if (pready !== 1'b1) begin
            num_errors++;
            give_verdict();
        end
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        // Idle cycle keeps each strobe to one assignment per time step
        @(posedge pclk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        logic [31:0] r;
        logic        e;
        int          n;
        apb(1'b1, a, d, s, r, e, n);
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic        e;
        int          n;
        apb(1'b0, a, 32'h0, 4'hf, r, e, n);
        chk(r, exp);
    endtask

    // ========================================
    // Scenarios
    task automatic reg_access();
        logic [31:0] r;
        logic        e;
        int          n;
        for (int i = 0; i < 4; i++) rd_chk(12'(4 * i), 32'h0);
        wr(crcu_pkg::OFS_CHECKSUM, 32'hffff_ffff, 4'hf);
        rd_chk(crcu_pkg::OFS_CHECKSUM, 32'h0);
        wr(crcu_pkg::OFS_SEED, 32'h1234_5678, 4'hf);
        rd_chk(crcu_pkg::OFS_SEED, 32'h0);
        apb(1'b1, 12'h010, 32'h0000_00ff, 4'hf, r, e, n);
        chk({31'h0, e}, 32'h1);
        apb(1'b0, 12'h010, 32'h0, 4'hf, r, e, n);
        chk({31'h0, e}, 32'h1);
        rd_chk(crcu_pkg::OFS_CONTROL, 32'h0);
    endtask

    task automatic known_vectors();
        logic [7:0]  sel [3] = '{8'h00, 8'h01, 8'h02};
        logic [31:0] sds [3] = '{32'h0000_ffff, 32'h0, 32'hffff_ffff};
        logic [31:0] res [3] = '{32'h0000_29b1, 32'h0000_fee8, 32'h0376_e6e7};
        for (int k = 0; k < 3; k++) begin
            wr(crcu_pkg::OFS_CONTROL, {24'h0, sel[k]}, 4'hf);
            wr(crcu_pkg::OFS_SEED, sds[k], 4'hf);
            for (int b = 1; b < 10; b++) wr(crcu_pkg::OFS_INPUT_DATA, 32'(48 + b), 4'h1);
            rd_chk(crcu_pkg::OFS_CHECKSUM, res[k]);
        end
    endtask

    task automatic run_case(input logic [7:0] c, input logic [31:0] sd, input logic [31:0] d,
                            input logic [3:0] s);
        logic [31:0] x;
        logic [31:0] r;
        logic        e;
        int          n;
        int          nb;
        nb = (s[3:2] != 2'b00) ? 4 : (s[1] ? 2 : (s[0] ? 1 : 0));
        wr(crcu_pkg::OFS_CONTROL, {24'h0, c}, 4'hf);
        wr(crcu_pkg::OFS_SEED, sd, 4'hf);
        m_state = c[1] ? sd : {16'h0, sd[15:0]};
        apb(1'b1, crcu_pkg::OFS_INPUT_DATA, d, s, r, e, n);
        x = c[4] ? ~d : d;
        if (nb == 4 && c[3]) x = {x[7:0], x[15:8], x[23:16], x[31:24]};
        if (nb == 2 && c[3]) x[15:0] = {x[7:0], x[15:8]};
        if (c[2]) x = flip4(x);
        for (int i = nb - 1; i >= 0; i--) m_state = step(m_state, x[8 * i +: 8], c[1:0]);
        apb(1'b0, crcu_pkg::OFS_CHECKSUM, 32'h0, 4'hf, r, e, n);
        chk(32'(n), 32'((nb == 0) ? 1 : nb));
        chk(r, shown(m_state, c));
        rd_chk(crcu_pkg::OFS_CONTROL, {24'h0, c});
    endtask

    task automatic run_cases();
        run_case(8'h00, 32'h0000_ffff, 32'h1234_5678, 4'hf);
        run_case(8'h01, 32'h0000_0000, 32'hdead_abcd, 4'h3);
        run_case(8'h02, 32'hffff_ffff, 32'hcafe_f00d, 4'hf);
        run_case(8'h03, 32'h1234_5678, 32'hffff_ff5a, 4'h1);
        run_case(8'h01, 32'habcd_1234, 32'h0102_0304, 4'h4);
        run_case(8'h12, 32'h0000_0000, 32'h8040_2010, 4'hf);
        run_case(8'h0a, 32'h0000_0000, 32'h8040_2010, 4'hf);
        run_case(8'h06, 32'h0000_0000, 32'h8040_2010, 4'hf);
        run_case(8'h08, 32'h0000_0000, 32'h0000_1180, 4'h2);
        run_case(8'h0c, 32'h0000_0000, 32'h0000_00c1, 4'h1);
        run_case(8'h1e, 32'h5a5a_a5a5, 32'h1357_9bdf, 4'hf);
        run_case(8'he2, 32'h0000_0000, 32'h8040_2010, 4'hf);
        run_case(8'h80, 32'h0000_ffff, 32'h0000_0031, 4'h1);
        run_case(8'h40, 32'h0000_1234, 32'h0000_0031, 4'h1);
        run_case(8'h21, 32'h0000_1234, 32'h0000_0031, 4'h1);
        run_case(8'h00, 32'h0000_1234, 32'h5555_5555, 4'h0);
        run_case(8'h18, 32'h0000_ffff, 32'h0000_00a5, 4'h1);
    endtask

    task automatic mid_reset();
        logic [31:0] r;
        logic        e;
        int          n;
        wr(crcu_pkg::OFS_CONTROL, 32'h0000_00fe, 4'hf);
        wr(crcu_pkg::OFS_SEED, 32'hffff_ffff, 4'hf);
        wr(crcu_pkg::OFS_INPUT_DATA, 32'h1234_5678, 4'hf);
        // Engine is still folding here; reset must clear it
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, crcu_pkg::OFS_CHECKSUM, 32'h0, 4'hf, r, e, n);
        chk(r, 32'h0);
        chk(32'(n), 32'h1);
        rd_chk(crcu_pkg::OFS_CONTROL, 32'h0);
    endtask

    // ========================================
    // Run control
    task automatic give_verdict();
        $display("comparisons=%0d num_errors=%0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        pclk        = 1'b0;
        presetn     = 1'b0;
        psel        = 1'b0;
        penable     = 1'b0;
        pwrite      = 1'b0;
        paddr       = 12'h000;
        pwdata      = 32'h0;
        pstrb       = 4'h0;
        num_errors  = 0;
        comparisons = 0;
        m_state     = 32'h0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        reg_access();
        known_vectors();
        run_cases();
        mid_reset();
        give_verdict();
    end

    // Generous bound: the whole sequence needs well under 2000 cycles
    initial begin
        repeat (6000) @(posedge pclk);
        num_errors++;
        give_verdict();
    end

endmodule

`default_nettype wire
